// file: bench/dac_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dac_port_monitor #(parameter int unsigned WAKE_CYCLES = 8) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic [1:0] clock_receiver_strap_i,
	input wire logic sleep_i,
	input wire logic sleep_connected_i,
	input wire logic sample_valid_i,
	input wire logic [8:0] primary_current_output_o,
	input wire logic [8:0] complementary_current_output_o,
	input wire logic output_valid_o,
	input wire logic powered_down_o,
	input wire logic [2:0] clock_mode_o
);
	wire logic [8:0] pri = primary_current_output_o;
	wire logic [1:0] st = clock_receiver_strap_i;
	wire logic ov = output_valid_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_sum; ov && $past(ov) |-> pri + complementary_current_output_o == 9'h0ff; endproperty
	a_sum: assert property (p_sum) else $error("sum");
	property p_off; !ov |-> pri == 9'h000; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_enter; $rose(sleep_i && sleep_connected_i) |-> ##[1:5] !ov; endproperty
	a_enter: assert property (p_enter) else $error("enter");
	property p_pull; !sleep_connected_i [*4] ##0 ov |=> ov; endproperty
	a_pull: assert property (p_pull) else $error("pull");
	property p_mode; $stable(st) [*4] |-> clock_mode_o == (st[1] ? 3'h4 : st[0] ? 3'h2 : 3'h1); endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_hold; (ov && !sample_valid_i) [*3] |=> !ov || $stable(pri); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_flag; $fell(ov) |=> powered_down_o; endproperty
	a_flag: assert property (p_flag) else $error("flag");
	property p_wake; $rose(ov) |-> !$past(sleep_i, WAKE_CYCLES); endproperty
	a_wake: assert property (p_wake) else $error("wake");
	cover property ($rose(ov));
	cover property ($fell(ov));
	cover property (clock_mode_o == 3'h4);
	cover property (ov && pri == 9'h0ff);
endmodule : dac_port_monitor
bind dac_sample_input_port dac_port_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) dac_port_monitor_inst (
	.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i),
	.clock_receiver_strap_i(clock_receiver_strap_i),
	.sleep_i(sleep_i),
	.sleep_connected_i(sleep_connected_i),
	.sample_valid_i(sample_valid_i),
	.primary_current_output_o(primary_current_output_o),
	.complementary_current_output_o(complementary_current_output_o),
	.output_valid_o(output_valid_o),
	.powered_down_o(powered_down_o),
	.clock_mode_o(clock_mode_o)
);
`default_nettype wire

// file: bench/drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_model (
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic run_i,
	output logic [7:0] sample_o = 8'h00,
	output logic valid_o = 1'h0
);
	int seed = 20702;
	int n = 0;
	logic took = 1'h0;
	always @(posedge clk_i) took <= valid_o && ready_i;
	// Each new word flips bit 0, so it always shows at the outputs; an idle bus changes every cycle.
	// The first two words are the all-ones and all-zeros corners, then words are random.
	always @(negedge clk_i) if (!valid_o || took) begin
		valid_o <= run_i;
		n <= run_i ? n + 1 : n;
		if (!run_i) sample_o <= sample_o ^ 8'hfe;
		else if (n < 2) sample_o <= (n == 0) ? 8'hff : 8'h00;
		else sample_o <= {7'($random(seed)), ~sample_o[0]};
	end
endmodule : drive_model
`default_nettype wire

// file: bench/test_dac_sample_input_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_dac_sample_input_port;
	logic core_clk_i = 1'h0, arst_n_i = 1'h0, sleep_i = 1'h0, sleep_connected_i = 1'h1, run = 1'h0;
	logic sample_valid_i, sample_ready_o, output_valid_o, powered_down_o;
	logic [1:0] clock_receiver_strap_i = 2'h0;
	logic [2:0] clock_mode_o;
	logic [7:0] sample_i, word, q[$];
	logic [8:0] primary_current_output_o, complementary_current_output_o, last = 9'h1ff;
	int miscompares = 0, checks = 0, cyc = 0;
	always #5 core_clk_i = ~core_clk_i;
	dac_sample_input_port #(.WAKE_CYCLES(8)) dac_sample_input_port_inst (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.sample_i(sample_i),
		.sample_valid_i(sample_valid_i),
		.sample_ready_o(sample_ready_o),
		.clock_receiver_strap_i(clock_receiver_strap_i),
		.sleep_i(sleep_i),
		.sleep_connected_i(sleep_connected_i),
		.primary_current_output_o(primary_current_output_o),
		.complementary_current_output_o(complementary_current_output_o),
		.output_valid_o(output_valid_o),
		.powered_down_o(powered_down_o),
		.clock_mode_o(clock_mode_o)
	);
	drive_model drive_model_inst (.clk_i(core_clk_i), .ready_i(sample_ready_o), .run_i(run),
		.sample_o(sample_i), .valid_o(sample_valid_i));
	task check(input logic [8:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task hold(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : hold
	function logic [8:0] level(input logic b);
		return {8'h00, b};
	endfunction : level
	function logic [8:0] remainder(input logic [7:0] c);
		return {1'b0, 8'hff - c};
	endfunction : remainder
	function logic [8:0] mode_of(input logic [1:0] st);
		return (st == 2'h0) ? 9'h001 : (st == 2'h1) ? 9'h002 : 9'h004;
	endfunction : mode_of
	always @(posedge core_clk_i) begin
		if (arst_n_i && sample_valid_i && sample_ready_o) q.push_back(sample_i);
		if (++cyc == 2000) begin
			miscompares++;
			conclude();
		end
	end
	// A new output value must be the oldest word taken; after a wake the first value is noted and only its complement is checked.
	always @(negedge core_clk_i) begin
		if (!output_valid_o || last === 9'h1ff) begin
			last = output_valid_o ? primary_current_output_o : 9'h1ff;
			if (output_valid_o) check(complementary_current_output_o, remainder(last[7:0]));
		end else if (primary_current_output_o !== last) begin
			last = primary_current_output_o;
			word = q.pop_front();
			check(last, {1'b0, word});
			check(complementary_current_output_o, remainder(word));
		end
	end
	initial begin
		hold(3);
		arst_n_i <= 1'h1;
		run <= 1'h1;
		hold(60);
		for (int s = 0; s < 4; s++) begin
			clock_receiver_strap_i <= 2'(s);
			hold(5);
			check(9'(clock_mode_o), mode_of(2'(s)));
		end
		$display("stream done");
		sleep_i <= 1'h1;
		sleep_connected_i <= 1'h0;
		hold(20);
		check(level(output_valid_o), 9'h001);
		run <= 1'h0;
		sleep_connected_i <= 1'h1;
		hold(5);
		check({powered_down_o, output_valid_o, primary_current_output_o[6:0]}, 9'h100);
		run <= 1'h1;
		hold(10);
		check(level(sample_ready_o), 9'h000);
		sleep_i <= 1'h0;
		hold(20);
		run <= 1'h0;
		hold(8);
		check(9'(q.size()), 9'h000);
		$display("sleep done");
		conclude();
	end
endmodule : test_dac_sample_input_port
`default_nettype wire

// file: core/dac_port_cfg.svh
`ifndef DAC_PORT_CFG_SVH
`define DAC_PORT_CFG_SVH
`define SAMPLE_W 8
`define CODE_SPAN 9'h100
`define CODE_TOP 8'hff
`define CLK_PERIOD_NS 10
`define SLEEP_ENTER_NS 50
`define SLEEP_ENTER_CYC ((`SLEEP_ENTER_NS) / (`CLK_PERIOD_NS))
`define WAKE_US 5
`define WAKE_CYC (((`WAKE_US) * 1000) / (`CLK_PERIOD_NS))
`define MAX_RATE_MSPS 165
`define SAMPLE_RST 8'h00
`endif

// file: core/dac_port_pkg.sv
`default_nettype none
package dac_port_pkg;
	typedef enum logic [2:0] {
		CLK_SINGLE = 3'b001,
		CLK_DIFF = 3'b010,
		CLK_TERM = 3'b100
	} clk_mode_t;
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_DOWN = 3'b010,
		PWR_WAKE = 3'b100
	} pwr_state_t;
	typedef enum logic [1:0] {
		STRAP_GND = 2'h0,
		STRAP_VDD = 2'h1,
		STRAP_OPEN = 2'h2
	} strap_t;
endpackage : dac_port_pkg
`default_nettype wire

// file: core/dac_sample_input_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_port_cfg.svh"
// Function
// RULE_01: The sample word is 8-bit unsigned binary, top bit most significant, bottom bit least.
// RULE_02: An all-ones captured word drives the primary output to full scale.
// RULE_03: The complementary output carries the remainder of full scale for the code.
// RULE_04: The sample word is captured in edge-triggered registers, never a transparent latch.
// RULE_05: The output changes only on a rising clock edge and shows the latest captured word.
// RULE_06: The port supports up to 165 MSPS and the driver keeps within that rate.
// RULE_07: The driver may use any duty cycle meeting the minimum pulse width.
// RULE_08: The driver should change data on the falling edge of a 50% duty clock.
// RULE_09: The clock strap selects single-ended, differential, or terminated differential receiver mode.
// RULE_10: In single-ended mode the driver swings the positive clock rail to rail, negative left open.
// RULE_11: While sleep is one the output current is off and the device is in low power.
// RULE_12: Sleep is pulled down, so an unconnected sleep leaves the device converting.
// RULE_13: Power-down occurs within 50 ns of sleep and output is valid about 5 us after release.
// RULE_14: Primary current is code/256 of full scale, complementary is (255-code)/256 of full scale.
module dac_sample_input_port
	import dac_port_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES = `WAKE_CYC
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Sample stream from the driving logic
	input wire logic [`SAMPLE_W-1:0] sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	// Static controls from pins
	input wire logic [1:0] clock_receiver_strap_i,
	input wire logic sleep_i,
	input wire logic sleep_connected_i,
	// Converter drive
	output logic [`SAMPLE_W:0] primary_current_output_o,
	output logic [`SAMPLE_W:0] complementary_current_output_o,
	output logic output_valid_o,
	output logic powered_down_o,
	output logic [2:0] clock_mode_o
);
	localparam logic [2:0] ENTER_CYC = 3'(`SLEEP_ENTER_CYC);

	function automatic logic [`SAMPLE_W:0] primary_of(input logic [`SAMPLE_W-1:0] code);
		primary_of = {1'b0, code}; // [RULE_14] [RULE_02]
	endfunction : primary_of

	function automatic logic [`SAMPLE_W:0] compl_of(input logic [`SAMPLE_W-1:0] code);
		compl_of = {1'b0, `CODE_TOP - code}; // [RULE_14] [RULE_03]
	endfunction : compl_of

	// Pin synchronisers.
	// Straps and sleep are pins outside the clock domain; only the second flop feeds any decode.
	logic [1:0] strap_s1_r, strap_s2_r, strap_s1_nxt, strap_s2_nxt;
	logic sleep_s1_r, sleep_s2_r, sleep_s1_nxt, sleep_s2_nxt;
	always_comb begin
		strap_s1_nxt = clock_receiver_strap_i;
		strap_s2_nxt = strap_s1_r;
		// An open sleep pin reads as low because of the pull-down.
		sleep_s1_nxt = sleep_i & sleep_connected_i; // [RULE_12]
		sleep_s2_nxt = sleep_s1_r;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
			sleep_s1_r <= 1'b0;
			sleep_s2_r <= 1'b0;
		end else begin
			strap_s1_r <= strap_s1_nxt;
			strap_s2_r <= strap_s2_nxt;
			sleep_s1_r <= sleep_s1_nxt;
			sleep_s2_r <= sleep_s2_nxt;
		end
	end

	// Clock receiver mode.
	clk_mode_t mode_r, mode_nxt;
	always_comb begin
		case (strap_t'(strap_s2_r)) // [RULE_09]
			STRAP_GND: mode_nxt = CLK_SINGLE;
			STRAP_VDD: mode_nxt = CLK_DIFF;
			default: mode_nxt = CLK_TERM;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_r <= CLK_SINGLE;
		end else begin
			mode_r <= mode_nxt;
		end
	end
	assign clock_mode_o = mode_r;

	// Power state: down quickly, back up after a long wake wait.
	// A sleep request during the wake wait returns to power-down, and the full wait starts again.
	pwr_state_t pwr_r, pwr_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	always_comb begin
		pwr_nxt = pwr_r;
		cnt_nxt = cnt_r;
		case (pwr_r)
			PWR_RUN: begin
				if (sleep_s2_r) begin
					pwr_nxt = PWR_DOWN; // [RULE_11] [RULE_13]
				end
			end
			PWR_DOWN: begin
				if (!sleep_s2_r) begin
					pwr_nxt = PWR_WAKE;
					cnt_nxt = 32'd0;
				end
			end
			PWR_WAKE: begin
				if (sleep_s2_r) begin
					pwr_nxt = PWR_DOWN;
				end else if (cnt_r >= WAKE_CYCLES - 1) begin
					pwr_nxt = PWR_RUN; // [RULE_13]
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			default: pwr_nxt = PWR_DOWN;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwr_r <= PWR_RUN;
			cnt_r <= 32'd0;
		end else begin
			pwr_r <= pwr_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Two-entry skid buffer in the sample path; drained one word per edge while running.
	// Words offered while the converter sleeps are held; once two are held, ready drops and the driver stalls.
	logic [`SAMPLE_W-1:0] buf0_r, buf1_r, buf0_nxt, buf1_nxt;
	logic [1:0] fill_r, fill_nxt;
	logic drain;
	logic take;
	always_comb begin
		drain = (pwr_r == PWR_RUN) && (fill_r != 2'd0);
		sample_ready_o = (fill_r != 2'd2); // [RULE_06]
		take = sample_valid_i && sample_ready_o;
		buf0_nxt = buf0_r;
		buf1_nxt = buf1_r;
		fill_nxt = fill_r;
		case ({take, drain})
			2'b10: begin
				if (fill_r == 2'd0) begin
					buf0_nxt = sample_i;
				end else begin
					buf1_nxt = sample_i;
				end
				fill_nxt = fill_r + 2'd1;
			end
			2'b01: begin
				buf0_nxt = buf1_r;
				fill_nxt = fill_r - 2'd1;
			end
			2'b11: begin
				if (fill_r == 2'd1) begin
					buf0_nxt = sample_i;
				end else begin
					buf0_nxt = buf1_r;
					buf1_nxt = sample_i;
				end
			end
			default: begin
				fill_nxt = fill_r;
			end
		endcase
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			buf0_r <= `SAMPLE_RST;
			buf1_r <= `SAMPLE_RST;
			fill_r <= 2'd0;
		end else begin
			buf0_r <= buf0_nxt;
			buf1_r <= buf1_nxt;
			fill_r <= fill_nxt;
		end
	end

	// Edge-triggered capture register and output currents.
	// The currents follow the next power state, so they drop on the same edge that clears output_valid_o.
	// The powered-down flag is registered from the state and trails output_valid_o by one edge.
	logic [`SAMPLE_W-1:0] code_r, code_nxt;
	logic [`SAMPLE_W:0] pri_r, pri_nxt, cmp_r, cmp_nxt;
	logic [2:0] down_cnt_r, down_cnt_nxt;
	always_comb begin
		code_nxt = drain ? buf0_r : code_r; // [RULE_04] [RULE_05] [RULE_01]
		down_cnt_nxt = (pwr_r == PWR_RUN) ? 3'd0 : (down_cnt_r < ENTER_CYC ? down_cnt_r + 3'd1 : down_cnt_r);
		if (pwr_nxt != PWR_RUN) begin
			pri_nxt = '0; // [RULE_11]
			cmp_nxt = '0;
		end else begin
			pri_nxt = primary_of(code_nxt); // [RULE_02] [RULE_03]
			cmp_nxt = compl_of(code_nxt);
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			code_r <= `SAMPLE_RST;
			pri_r <= '0;
			// Reset leaves the pair summing to full scale for the reset code.
			cmp_r <= {1'b0, `CODE_TOP - `SAMPLE_RST}; // [RULE_03]
			down_cnt_r <= 3'd0;
		end else begin
			code_r <= code_nxt;
			pri_r <= pri_nxt;
			cmp_r <= cmp_nxt;
			down_cnt_r <= down_cnt_nxt;
		end
	end
	assign primary_current_output_o = pri_r;
	assign complementary_current_output_o = cmp_r;
	assign output_valid_o = (pwr_r == PWR_RUN);
	assign powered_down_o = (down_cnt_r != 3'd0);
endmodule : dac_sample_input_port
`default_nettype wire
